// [usart_timeout_guard.sv]
// Receive time-out, transmit time-guard and two data channels of a serial
// transceiver, behind an AXI4-Lite register slave.
// Assumes the baud generator gives one bit_tick pulse per bit period and
// the shifters report character ends; all inputs are synchronous to clk.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module utg_usart_timeout_guard #(
  parameter int CHAR_W = 9,
  parameter int PTR_STEP = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bit_tick,
  input wire logic rxd,
  input wire logic rx_char_done,
  input wire logic [CHAR_W-1:0] rx_char,
  input wire logic receiver_ready,
  output logic rx_char_taken,
  input wire logic tx_char_done,
  input wire logic txd_shift,
  output logic txd,
  input wire logic transmitter_ready,
  output logic tx_hold_load,
  output logic [CHAR_W-1:0] tx_hold_data,
  output logic rx_mem_req,
  output logic [31:0] rx_mem_addr,
  output logic [CHAR_W-1:0] rx_mem_wdata,
  input wire logic rx_mem_ack,
  output logic tx_mem_req,
  output logic [31:0] tx_mem_addr,
  input wire logic [CHAR_W-1:0] tx_mem_rdata,
  input wire logic tx_mem_ack,
  output logic rx_channel_done,
  output logic tx_channel_done,
  output logic timeout_flag,
  output logic guard_active
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] timeout_value;
    logic [7:0] guard_time_value;
    logic rx_started;
    logic tmo_flag;
    logic txd;
    logic aw_full;
    logic w_full;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [CHAR_W-1:0] rx_wdata;
    logic rx_take;
    logic tx_load;
    logic [CHAR_W-1:0] tx_data;
  } utg_top_t;

  utg_top_t s;
  utg_top_t next_s;

  logic [31:0] rx_ptr;
  logic [15:0] rx_cnt;
  logic [31:0] tx_ptr;
  logic [15:0] tx_cnt;
  logic tmo_busy;
  logic tmo_expired;
  logic guard_busy;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic rto_write;
  logic rx_ptr_we;
  logic rx_cnt_we;
  logic tx_ptr_we;
  logic tx_cnt_we;
  logic tmo_load;
  logic [7:0] tmo_value;

  // Byte lanes without a strobe keep the register's old contents.
  function automatic logic [31:0] utg_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : utg_merge

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // A write runs once both halves are held and no response is pending.
  assign wr_en = s.aw_full && s.w_full && !s.bvalid;
  assign wr_addr = {s.awaddr[7:2], 2'b00};
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};

  // Old contents of the addressed register, for strobe merging.
  always_comb begin
    case (wr_addr)
      utg_pkg::OFF_RX_TIMEOUT: wr_old = {24'h000000, s.timeout_value};
      utg_pkg::OFF_TX_GUARD: wr_old = {24'h000000, s.guard_time_value};
      utg_pkg::OFF_RX_PTR: wr_old = rx_ptr;
      utg_pkg::OFF_RX_CNT: wr_old = {16'h0000, rx_cnt};
      utg_pkg::OFF_TX_PTR: wr_old = tx_ptr;
      utg_pkg::OFF_TX_CNT: wr_old = {16'h0000, tx_cnt};
      default: wr_old = 32'h0000_0000;
    endcase
  end

  assign wr_val = utg_merge(wr_old, s.wdata, s.wstrb);
  assign rto_write = wr_en && wr_addr == utg_pkg::OFF_RX_TIMEOUT;
  assign rx_ptr_we = wr_en && wr_addr == utg_pkg::OFF_RX_PTR;
  assign rx_cnt_we = wr_en && wr_addr == utg_pkg::OFF_RX_CNT;
  assign tx_ptr_we = wr_en && wr_addr == utg_pkg::OFF_TX_PTR;
  assign tx_cnt_we = wr_en && wr_addr == utg_pkg::OFF_TX_CNT;

  // ****************************************************************
  // Receive time-out
  // ****************************************************************
  // Any write to the time-out register is a start command and reloads
  // the counter with the freshly written value.
  assign tmo_load = rto_write || rx_char_done;
  assign tmo_value = rto_write ? wr_val[7:0] : s.timeout_value;

  utg_timer #(
    .PRE(utg_pkg::TIMEOUT_BITS_PER_STEP)
  ) u_timeout (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .load(tmo_load),
    .value(tmo_value),
    .tick(bit_tick),
    .run(s.rx_started && rxd),
    .busy(tmo_busy),
    .expired(tmo_expired)
  );

  // ****************************************************************
  // Transmit time-guard
  // ****************************************************************
  // The guard starts at each character end; a zero value never starts it.
  utg_timer #(
    .PRE(utg_pkg::GUARD_BITS_PER_STEP)
  ) u_guard (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .load(tx_char_done),
    .value(s.guard_time_value),
    .tick(bit_tick),
    .run(1'b1),
    .busy(guard_busy),
    .expired()
  );

  // ****************************************************************
  // Data channels
  // ****************************************************************
  // Receive channel moves the holding character out to memory.
  utg_channel #(
    .STEP(PTR_STEP)
  ) u_rx_chan (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .ptr_we(rx_ptr_we),
    .cnt_we(rx_cnt_we),
    .wdata(wr_val),
    .trigger(receiver_ready),
    .ack(rx_mem_ack),
    .ptr(rx_ptr),
    .cnt(rx_cnt),
    .req(rx_mem_req),
    .done(rx_channel_done)
  );

  // Transmit channel fetches the next character into the holding stage.
  utg_channel #(
    .STEP(PTR_STEP)
  ) u_tx_chan (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .ptr_we(tx_ptr_we),
    .cnt_we(tx_cnt_we),
    .wdata(wr_val),
    .trigger(transmitter_ready),
    .ack(tx_mem_ack),
    .ptr(tx_ptr),
    .cnt(tx_cnt),
    .req(tx_mem_req),
    .done(tx_channel_done)
  );

  assign rx_mem_addr = rx_ptr;
  assign tx_mem_addr = tx_ptr;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Bus slave, configuration registers, flags and line output.
  always_comb begin
    next_s = s;
    next_s.rx_take = 1'b0;
    next_s.tx_load = 1'b0;
    // Address and data are taken in either order.
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_en) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = utg_pkg::RESP_OKAY;
      case (wr_addr)
        utg_pkg::OFF_RX_TIMEOUT: next_s.timeout_value = wr_val[7:0];
        utg_pkg::OFF_TX_GUARD: next_s.guard_time_value = wr_val[7:0];
        utg_pkg::OFF_RX_PTR, utg_pkg::OFF_RX_CNT, utg_pkg::OFF_TX_PTR,
        utg_pkg::OFF_TX_CNT, utg_pkg::OFF_STATUS: begin
          next_s.bresp = utg_pkg::RESP_OKAY;
        end
        default: next_s.bresp = utg_pkg::RESP_DECERR;
      endcase
    end
    next_s.awready = !next_s.aw_full;
    next_s.wready = !next_s.w_full;
    // Reads answer on the edge that takes the address.
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = utg_pkg::RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      case (rd_addr)
        utg_pkg::OFF_RX_TIMEOUT: next_s.rdata[7:0] = s.timeout_value;
        utg_pkg::OFF_TX_GUARD: next_s.rdata[7:0] = s.guard_time_value;
        utg_pkg::OFF_RX_PTR: next_s.rdata = rx_ptr;
        utg_pkg::OFF_RX_CNT: next_s.rdata[15:0] = rx_cnt;
        utg_pkg::OFF_TX_PTR: next_s.rdata = tx_ptr;
        utg_pkg::OFF_TX_CNT: next_s.rdata[15:0] = tx_cnt;
        utg_pkg::OFF_STATUS: begin
          next_s.rdata[utg_pkg::STAT_TIMEOUT] = s.tmo_flag;
          next_s.rdata[utg_pkg::STAT_RX_DONE] = rx_channel_done;
          next_s.rdata[utg_pkg::STAT_TX_DONE] = tx_channel_done;
          next_s.rdata[utg_pkg::STAT_GUARD] = guard_busy;
        end
        default: next_s.rresp = utg_pkg::RESP_DECERR;
      endcase
    end
    next_s.arready = !next_s.rvalid;
    // Reception counts as started from the first character after a start.
    if (rto_write) begin
      next_s.rx_started = 1'b0;
      next_s.tmo_flag = 1'b0;
    end
    if (rx_char_done) begin
      next_s.rx_started = 1'b1;
    end
    // Expiry set wins over a start clear in the same cycle.
    if (tmo_expired) begin
      next_s.tmo_flag = 1'b1;
    end
    if (next_s.timeout_value == 8'h00) begin
      next_s.tmo_flag = 1'b0;
    end
    // Guard forces the line to its idle high level.
    next_s.txd = txd_shift || guard_busy;
    // Receive data is sampled while no request is open, so it matches.
    if (!rx_mem_req) begin
      next_s.rx_wdata = rx_char;
    end
    if (rx_mem_req && rx_mem_ack) begin
      next_s.rx_take = 1'b1;
    end
    if (tx_mem_req && tx_mem_ack) begin
      next_s.tx_load = 1'b1;
      next_s.tx_data = tx_mem_rdata;
    end
  end

  // State register; the line idles high from reset.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
      s.timeout_value <= utg_pkg::RST_TIMEOUT;
      s.guard_time_value <= utg_pkg::RST_GUARD;
      s.txd <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign rx_char_taken = s.rx_take;
  assign txd = s.txd;
  assign tx_hold_load = s.tx_load;
  assign tx_hold_data = s.tx_data;
  assign rx_mem_wdata = s.rx_wdata;
  assign timeout_flag = s.tmo_flag;
  assign guard_active = guard_busy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  start_reload_a: assert property (ce && rto_write
    |=> tmo_busy == ($past(wr_val[7:0]) != 8'h00))
    else $error("time-out start did not reload the counter");
  start_clear_a: assert property (ce && rto_write && !tmo_expired
    |=> !timeout_flag)
    else $error("time-out flag not cleared by start");
  zero_disable_a: assert property (s.timeout_value == 8'h00
    |-> !timeout_flag && !tmo_busy)
    else $error("time-out active with zero value");
  expiry_flag_a: assert property (ce && tmo_expired && !rto_write
    && s.timeout_value != 8'h00
    |=> timeout_flag ##1 (timeout_flag || $past(ce && rto_write)))
    else $error("time-out flag not set on expiry");
  guard_high_a: assert property (ce && guard_busy |=> txd)
    else $error("line not held high during guard");
  guard_off_a: assert property (ce && tx_char_done
    && s.guard_time_value == 8'h00 && !guard_busy |=> !guard_busy)
    else $error("guard started with zero value");
  rx_move_a: assert property (ce && rx_mem_req && rx_mem_ack
    && !rx_cnt_we |=> rx_char_taken ##1 (!rx_char_taken || !$past(ce)))
    else $error("receive move not reported once");

  tmo_seen_c: cover property (tmo_expired ##1 timeout_flag);
  rx_end_c: cover property (!rx_channel_done ##1 rx_channel_done);
  guard_seen_c: cover property (tx_char_done ##1 guard_busy);
  bus_write_c: cover property (s_axi_bvalid && s_axi_bready);

endmodule : utg_usart_timeout_guard
`default_nettype wire

// [usart_timeout_guard_dma_test.sv]
// Self-checking bench for the time-out, time-guard and data channels.
// Assumes utg_pkg, utg_usart_timeout_guard and utg_mem_model are compiled.
`timescale 1ns/1ps
`default_nettype none
`define chk(g, e) begin comparisons++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected at %0t: got %0h", $time, g); end end
module usart_timeout_guard_dma_test;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, rxd = 1'b1, txd_shift = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, seed = 32'h0000_6B7A, rx_mem_addr;
  logic [3:0] s_axi_wstrb = 4'hF, ack_delay = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, bit_tick = 0, rx_char_done = 0;
  logic receiver_ready = 0, tx_char_done = 0, transmitter_ready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_char_taken, txd, tx_hold_load, rx_mem_req;
  logic tx_mem_req, rx_mem_ack, tx_mem_ack, rx_channel_done;
  logic tx_channel_done, timeout_flag, guard_active;
  logic [1:0] s_axi_bresp, s_axi_rresp, tc = 2'h0;
  logic [31:0] s_axi_rdata, tx_mem_addr;
  logic [8:0] rx_char = 9'h0, tx_hold_data, rx_mem_wdata, tx_mem_rdata;
  logic [33:0] q[$];
  logic [33:0] rd_got;
  int n_mismatch = 0, comparisons = 0, rx_want = 0, tx_want = 0;
  int rx_given = 0, tx_given = 0;
  utg_usart_timeout_guard #(.CHAR_W(9), .PTR_STEP(1))
    utg_usart_timeout_guard_i (.*);
  utg_mem_model utg_mem_model_i (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  always #2 clk = ~clk;
  // Bit period of four clocks; ready falls once the character is moved.
  always @(posedge clk) begin
    tc <= tc + 2'h1;
    bit_tick <= (tc == 2'h3);
    if (rx_char_taken) receiver_ready <= 1'b0;
    else if (!receiver_ready && rx_given < rx_want) begin
      receiver_ready <= 1'b1;
      rx_char <= 9'(xs());
      rx_given <= rx_given + 1;
    end
    if (tx_hold_load) transmitter_ready <= 1'b0;
    else if (!transmitter_ready && tx_given < tx_want) begin
      transmitter_ready <= 1'b1;
      tx_given <= tx_given + 1;
    end
  end
  // Read data only counts when the answer is OKAY.
  assign rd_got = {s_axi_rresp, s_axi_rresp == 2'h0 ? s_axi_rdata : 32'h0};
  // Each result seen is matched against the oldest expectation noted; the
  // moved character must be the one the receiver still offers.
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready)
      `chk({s_axi_bresp, 32'h0}, q.pop_front())
    if (s_axi_rvalid && s_axi_rready)
      `chk(rd_got, q.pop_front())
    if (rx_mem_req && rx_mem_ack)
      `chk({2'h0, rx_mem_addr}, q.pop_front())
    if (rx_mem_req && rx_mem_ack)
      `chk(rx_mem_wdata, rx_char)
    if (tx_mem_req && tx_mem_ack)
      `chk({2'h0, tx_mem_addr}, q.pop_front())
    if (tx_hold_load) `chk({25'h0, tx_hold_data}, q.pop_front())
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    q.push_back(34'h0);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // Ready stays high, so the next call never lowers and raises it at once.
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask : rd
  task automatic pulse(input logic tx);
    if (tx) tx_char_done <= 1'b1;
    else rx_char_done <= 1'b1;
    @(posedge clk);
    tx_char_done <= 1'b0;
    rx_char_done <= 1'b0;
  endtask : pulse
  // Counts guard cycles after one character; txd must follow them high.
  task automatic guard(input logic [7:0] v, input int lo, input int hi);
    int n;
    logic g;
    n = 0;
    g = 1'b0;
    wr(8'h04, {24'hFFFFFF, v});
    rd(8'h04, {26'h0, v});
    pulse(1'b1);
    repeat (40) begin
      @(posedge clk);
      if (g) `chk(txd, 1'b1)
      g = guard_active;
      n += int'(g);
    end
    `chk(n >= lo && n <= hi, 1'b1)
  endtask : guard
  task automatic stop_test();
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // The whole run needs some 500 cycles; this limit is fourteen times that.
  initial begin
    #28000;
    n_mismatch++;
    stop_test();
  end
  // Main sequence: registers, time-out, guard, then both channels.
  initial begin
    logic [31:0] p;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 34'h0);
    rd(8'h18, 34'h6);
    rd(8'h1C, {2'h3, 32'h0});
    wr(8'h00, 32'h3);
    pulse(1'b0);
    repeat (24) @(posedge clk);
    `chk(timeout_flag, 1'b0)
    pulse(1'b0);
    repeat (28) @(posedge clk);
    `chk(timeout_flag, 1'b0)
    repeat (30) @(posedge clk);
    `chk(timeout_flag, 1'b1)
    rd(8'h18, 34'h7);
    wr(8'h00, 32'h3);
    pulse(1'b0);
    rxd <= 1'b0;
    repeat (60) @(posedge clk);
    `chk(timeout_flag, 1'b0)
    rxd <= 1'b1;
    repeat (60) @(posedge clk);
    `chk(timeout_flag, 1'b1)
    wr(8'h00, 32'h0);
    pulse(1'b0);
    repeat (40) @(posedge clk);
    `chk(timeout_flag, 1'b0)
    guard(8'h03, 9, 12);
    guard(8'h00, 0, 0);
    rx_want = 2;
    tx_want = 1;
    repeat (20) @(posedge clk);
    `chk(rx_mem_req | tx_mem_req, 1'b0)
    p = xs();
    wr(8'h08, p);
    wr(8'h0C, 32'h2);
    rd(8'h18, 34'h4);
    q.push_back({2'h0, p});
    q.push_back({2'h0, p + 32'h1});
    repeat (60) @(posedge clk);
    `chk(rx_channel_done, 1'b1)
    rd(8'h08, {2'h0, p + 32'h2});
    ack_delay <= 4'h0;
    p = xs();
    wr(8'h10, p);
    wr(8'h14, 32'h1);
    q.push_back({2'h0, p});
    q.push_back({25'h0, p[8:0] ^ 9'h1A5});
    repeat (20) @(posedge clk);
    `chk(tx_channel_done, 1'b1)
    rd(8'h14, 34'h0);
    stop_test();
  end
endmodule : usart_timeout_guard_dma_test
`default_nettype wire

// [utg_channel.sv]
// One data channel: buffer pointer, item counter and memory request.
// Assumes memory answers a request with a one-cycle ack pulse.
`timescale 1ns/1ps
`default_nettype none
module utg_channel #(
  parameter int STEP = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic ptr_we,
  input wire logic cnt_we,
  input wire logic [31:0] wdata,
  input wire logic trigger,
  input wire logic ack,
  output logic [31:0] ptr,
  output logic [15:0] cnt,
  output logic req,
  output logic done
);

  typedef struct packed {
    logic [31:0] ptr;
    logic [15:0] cnt;
    logic req;
    logic gap;
    logic done;
  } utg_chan_t;

  utg_chan_t s;
  utg_chan_t next_s;

  // The gap cycle after each move lets the ready level fall first, so a
  // single character is never moved twice.
  always_comb begin
    next_s = s;
    next_s.gap = 1'b0;
    if (s.req && ack) begin
      next_s.req = 1'b0;
      next_s.gap = 1'b1;
      next_s.ptr = s.ptr + 32'(STEP);
      next_s.cnt = s.cnt - 16'h0001;
    end else if (!s.req && !s.gap && s.cnt != 16'h0000 && trigger) begin
      next_s.req = 1'b1;
    end
    if (ptr_we) begin
      next_s.ptr = wdata;
    end
    if (cnt_we) begin
      next_s.cnt = wdata[15:0];
      if (wdata[15:0] == 16'h0000) begin
        next_s.req = 1'b0;
      end
    end
    next_s.done = (next_s.cnt == 16'h0000);
  end

  // State register; an empty counter means the channel starts done.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
      s.ptr <= utg_pkg::RST_PTR;
      s.cnt <= utg_pkg::RST_CNT;
      s.done <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign ptr = s.ptr;
  assign cnt = s.cnt;
  assign req = s.req;
  assign done = s.done;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  idle_zero_a: assert property (ce && cnt == 16'h0000 && !req
    |=> !req)
    else $error("request raised with empty counter");
  start_move_a: assert property (ce && cnt != 16'h0000 && !req && !s.gap
    && trigger && !cnt_we |=> req)
    else $error("ready item not requested");
  move_step_a: assert property (ce && req && ack && !cnt_we && !ptr_we
    |=> cnt == $past(cnt) - 16'h0001 && ptr == $past(ptr) + 32'(STEP))
    else $error("pointer or counter not advanced");
  done_mirror_a: assert property (done == (cnt == 16'h0000))
    else $error("done flag disagrees with counter");

endmodule : utg_channel
`default_nettype wire

// [utg_mem_model.sv]
// Memory seen by the two data channels, answering after ack_delay cycles.
// Assumes each request is held until its one-cycle ack, as the design does.
`timescale 1ns/1ps
`default_nettype none
module utg_mem_model (
  input wire logic clk,
  input wire logic [3:0] ack_delay,
  input wire logic rx_mem_req,
  input wire logic tx_mem_req,
  input wire logic [31:0] tx_mem_addr,
  output var logic rx_mem_ack,
  output var logic tx_mem_ack,
  output logic [8:0] tx_mem_rdata
);
  logic [3:0] rx_wait;
  logic [3:0] tx_wait;
  // Data is valid only with the ack; otherwise the inverse, so a late
  // sample cannot match by luck.
  assign tx_mem_rdata = (tx_mem_addr[8:0] ^ 9'h1A5) ^ {9{!tx_mem_ack}};
  // One ack pulse per request after the programmed wait.
  initial begin
    rx_mem_ack = 1'b0;
    tx_mem_ack = 1'b0;
    rx_wait = 4'h0;
    tx_wait = 4'h0;
  end
  always @(posedge clk) begin
    rx_mem_ack <= rx_mem_req && !rx_mem_ack && rx_wait >= ack_delay;
    tx_mem_ack <= tx_mem_req && !tx_mem_ack && tx_wait >= ack_delay;
    rx_wait <= (rx_mem_req && !rx_mem_ack) ? rx_wait + 4'h1 : 4'h0;
    tx_wait <= (tx_mem_req && !tx_mem_ack) ? tx_wait + 4'h1 : 4'h0;
  end
endmodule : utg_mem_model
`default_nettype wire

// [utg_pkg.sv]
// Constants shared by the time-out, time-guard and data channel logic.
// Assumes 32-bit AXI4-Lite register access with byte addresses below 0x20.
package utg_pkg;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] OFF_RX_TIMEOUT = 8'h00;
  localparam logic [7:0] OFF_TX_GUARD = 8'h04;
  localparam logic [7:0] OFF_RX_PTR = 8'h08;
  localparam logic [7:0] OFF_RX_CNT = 8'h0C;
  localparam logic [7:0] OFF_TX_PTR = 8'h10;
  localparam logic [7:0] OFF_TX_CNT = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // ****************************************************************
  // Status register bit positions
  // ****************************************************************
  localparam int STAT_TIMEOUT = 0;
  localparam int STAT_RX_DONE = 1;
  localparam int STAT_TX_DONE = 2;
  localparam int STAT_GUARD = 3;

  // ****************************************************************
  // Values after reset and timing counts
  // ****************************************************************
  localparam logic [7:0] RST_TIMEOUT = 8'h00;
  localparam logic [7:0] RST_GUARD = 8'h00;
  localparam logic [31:0] RST_PTR = 32'h0000_0000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  // Bit periods per time-out counter step, and per time-guard step.
  localparam int TIMEOUT_BITS_PER_STEP = 4;
  localparam int GUARD_BITS_PER_STEP = 1;

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : utg_pkg

// [utg_timer.sv]
// Loadable down counter stepping once every PRE bit-period ticks.
// Assumes tick is a one-cycle pulse per bit period, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module utg_timer #(
  parameter int PRE = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic load,
  input wire logic [7:0] value,
  input wire logic tick,
  input wire logic run,
  output logic busy,
  output logic expired
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [2:0] pre;
    logic busy;
    logic expired;
  } utg_timer_t;

  utg_timer_t s;
  utg_timer_t next_s;

  // A load wins over counting; a zero value leaves the timer idle.
  always_comb begin
    next_s = s;
    next_s.expired = 1'b0;
    if (load) begin
      next_s.cnt = value;
      next_s.pre = 3'h0;
      next_s.busy = (value != 8'h00);
    end else if (s.busy && !run) begin
      next_s.pre = 3'h0;
    end else if (s.busy && tick) begin
      if (s.pre == 3'(PRE - 1)) begin
        next_s.pre = 3'h0;
        if (s.cnt == 8'h01) begin
          next_s.cnt = 8'h00;
          next_s.busy = 1'b0;
          next_s.expired = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end else begin
        next_s.pre = s.pre + 3'h1;
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign expired = s.expired;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  last_step_a: assert property (ce && !load && s.busy && run && tick
    && s.pre == 3'(PRE - 1) && s.cnt == 8'h01 |=> expired && !busy)
    else $error("timer did not expire on its last step");

endmodule : utg_timer
`default_nettype wire
